// ---- src/scp_loader.sv ----
`timescale 1ns/1ps
// Summary of operation
// - node id: first switch high, second low
// - 01-7F normal node, 81-FF pair mode
// - bit-rate code 0-7 to kbit/s, 9 init
// - illegal switch setting aborts boot
// - odd id partners plus one, even minus
// - pair mode enters operational by itself
// - partner input on drives same output channel
// - scan slots, map module process data
module scp_loader import scp_pkg::*; #(
   parameter int SLOTS = 8,
   parameter int DI_W = 16,
   parameter bit INIT_SUPPORT = 1'b1
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // rotary switch pins
   input wire logic [3:0] id_msb_sw,
   input wire logic [3:0] id_lsb_sw,
   input wire logic [3:0] rate_sw,
   // slot identification pins, KIND_W bits per slot
   input wire logic [SLOTS*KIND_W-1:0] slot_kind_pins,
   // local digital inputs and outputs
   input wire logic [DI_W-1:0] di_pins,
   output logic [DI_W-1:0] do_pins,
   // from the network side
   input wire logic nmt_start_cmd,
   input wire logic [DI_W-1:0] peer_di,
   input wire logic peer_di_valid,
   // boot result
   output logic [7:0] node_id,
   output logic [7:0] peer_id,
   output logic pair_mode,
   output logic [2:0] rate_sel,
   output logic [9:0] rate_kbps,
   output logic init_mode,
   output logic boot_done,
   output logic boot_fail,
   output logic operational,
   output logic nmt_self_start,
   // process data map
   output logic [SLOTS-1:0] tx_map,
   output logic [SLOTS-1:0] rx_map,
   // local input report towards the partner
   output logic [DI_W-1:0] di_report,
   output logic di_report_valid
);

   localparam int PIN_W = 12 + SLOTS*KIND_W + DI_W;
   localparam int IDX_W = (SLOTS > 1) ? $clog2(SLOTS) : 1;
   localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(SLOTS - 1);

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [PIN_W-1:0] pins_s;
   scp_sync #(.W(PIN_W)) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .d({id_msb_sw, id_lsb_sw, rate_sw, slot_kind_pins, di_pins}),
      .q(pins_s)
   );

   wire [7:0] id_s = pins_s[PIN_W-1 -: 8];
   wire [3:0] rate_s = pins_s[PIN_W-9 -: 4];
   wire [SLOTS*KIND_W-1:0] kind_s = pins_s[DI_W +: SLOTS*KIND_W];
   wire [DI_W-1:0] di_s = pins_s[DI_W-1:0];

   ////////////////////////////////////////////////////////////////////////
   // state and captured settings
   scp_state_t state;
   scp_state_t next_state;
   logic [1:0] settle_cnt;
   logic [7:0] cap_id;
   logic [3:0] cap_rate;
   logic [KIND_W-1:0] cap_kind [SLOTS];
   logic [IDX_W-1:0] scan_idx;
   logic [DI_W-1:0] di_last;

   wire settle_done = (settle_cnt == SETTLE_CYCLES);
   wire capture = (state == ST_SETTLE) && settle_done;
   wire id_normal = (cap_id >= ID_NORM_MIN) && (cap_id <= ID_NORM_MAX);
   wire id_pair = (cap_id >= ID_PAIR_MIN) && (cap_id <= ID_PAIR_MAX);
   wire init_req = INIT_SUPPORT && (cap_rate == RATE_INIT);
   wire rate_ok = (cap_rate <= RATE_LAST) || init_req;
   wire cfg_ok = (id_normal || id_pair) && rate_ok;
   wire scan_last = (state == ST_SCAN) && (scan_idx == IDX_LAST);
   wire [7:0] next_peer = cap_id[0] ? cap_id + ID_STEP
                                    : cap_id - ID_STEP;
   wire [KIND_W-1:0] scan_kind = cap_kind[scan_idx];
   wire pair_run = (state == ST_RUN) && pair_mode && operational;
   wire di_changed = pair_run && (di_s != di_last);
   always_comb begin
      next_state = state;
      case (state)
         ST_SETTLE: begin
            if (settle_done) begin
               next_state = ST_CHECK;
            end
         end
         ST_CHECK: begin
            if (!cfg_ok) begin
               next_state = ST_FAIL;
            end else if (init_req) begin
               next_state = ST_INIT;
            end else begin
               next_state = ST_SCAN;
            end
         end
         ST_SCAN: begin
            if (scan_idx == IDX_LAST) begin
               next_state = ST_RUN;
            end
         end
         default: next_state = state;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_SETTLE;
         settle_cnt <= 2'h0;
      end else begin
         state <= next_state;
         if (!settle_done) begin
            settle_cnt <= settle_cnt + 2'h1;
         end
      end
   end

   // the switches are read once; later turns wait for the next reset
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cap_id <= 8'h00;
         cap_rate <= 4'h0;
      end else if (capture) begin
         cap_id <= id_s;
         cap_rate <= rate_s;
      end
   end

   genvar g;
   generate
      for (g = 0; g < SLOTS; g++) begin : g_kind
         always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
               cap_kind[g] <= KIND_NONE;
            end else if (capture) begin
               cap_kind[g] <= kind_s[g*KIND_W +: KIND_W];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // slot scan, one slot per cycle
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         scan_idx <= '0;
         tx_map <= '0;
         rx_map <= '0;
      end else if (state == ST_SCAN) begin
         tx_map[scan_idx] <= scp_has_in(scan_kind);
         rx_map[scan_idx] <= scp_has_out(scan_kind);
         if (!scan_last) begin
            scan_idx <= scan_idx + IDX_W'(1);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // boot result
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         node_id <= 8'h00;
         peer_id <= 8'h00;
         pair_mode <= 1'b0;
         rate_sel <= 3'h0;
         rate_kbps <= 10'h000;
         boot_done <= 1'b0;
      end else if (scan_last) begin
         node_id <= cap_id;
         peer_id <= id_pair ? next_peer : 8'h00;
         pair_mode <= id_pair;
         rate_sel <= cap_rate[2:0];
         rate_kbps <= scp_kbps(cap_rate);
         boot_done <= 1'b1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         init_mode <= 1'b0;
         boot_fail <= 1'b0;
      end else if (state == ST_CHECK) begin
         init_mode <= cfg_ok && init_req;
         boot_fail <= !cfg_ok;
      end
   end

   // pair nodes start themselves; normal nodes wait for the master
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         operational <= 1'b0;
         nmt_self_start <= 1'b0;
      end else begin
         nmt_self_start <= scan_last && id_pair;
         if (scan_last && id_pair) begin
            operational <= 1'b1;
         end else if (state == ST_RUN && nmt_start_cmd) begin
            operational <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pair-connection data path
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         do_pins <= '0;
         di_last <= '0;
         di_report <= '0;
         di_report_valid <= 1'b0;
      end else begin
         if (pair_run && peer_di_valid) begin
            do_pins <= peer_di;
         end
         di_report_valid <= di_changed;
         if (di_changed) begin
            di_last <= di_s;
            di_report <= di_s;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions
   localparam int SCAN_MAX = SLOTS;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // high nibble from the first switch, low nibble from the second
   property p_id_compose;
      capture |=> cap_id[7:4] == $past(pins_s[PIN_W-1 -: 4]) &&
         cap_id[3:0] == $past(pins_s[PIN_W-5 -: 4]);
   endproperty
   a_id_compose: assert property (p_id_compose)
      else $error("node id differs from captured switches");
   property p_pair_sel;
      boot_done |-> pair_mode == node_id[7];
   endproperty
   a_pair_sel: assert property (p_pair_sel)
      else $error("pair mode does not follow id range");
   property p_rate_map;
      boot_done |-> rate_kbps == scp_kbps({1'b0, rate_sel});
   endproperty
   a_rate_map: assert property (p_rate_map)
      else $error("bit rate does not match switch code");
   property p_fail_blocks;
      boot_fail |-> !boot_done && !operational && state == ST_FAIL;
   endproperty
   a_fail_blocks: assert property (p_fail_blocks)
      else $error("node booted on illegal settings");
   property p_peer_id;
      boot_done && pair_mode |->
         peer_id == (node_id[0] ? node_id + ID_STEP : node_id - ID_STEP);
   endproperty
   a_peer_id: assert property (p_peer_id)
      else $error("wrong partner id");
   property p_self_start;
      $rose(boot_done) |-> operational == pair_mode &&
         nmt_self_start == pair_mode ##1 !nmt_self_start;
   endproperty
   a_self_start: assert property (p_self_start)
      else $error("pair node did not start itself");
   property p_do_follow;
      pair_run && peer_di_valid |=> do_pins == $past(peer_di);
   endproperty
   a_do_follow: assert property (p_do_follow)
      else $error("outputs did not follow partner inputs");
   property p_scan_bound;
      $rose(state == ST_SCAN) |-> ##[1:SCAN_MAX] $rose(boot_done);
   endproperty
   a_scan_bound: assert property (p_scan_bound)
      else $error("slot scan did not finish in time");
   property p_hold_cfg;
      state != ST_SETTLE |=> $stable(cap_id) && $stable(cap_rate);
   endproperty
   a_hold_cfg: assert property (p_hold_cfg)
      else $error("switch setting changed after capture");

   c_pair_boot: cover property ($rose(boot_done) && pair_mode);
   c_norm_boot: cover property ($rose(boot_done) && !pair_mode);
   c_fail: cover property ($rose(boot_fail));
   c_init: cover property ($rose(init_mode));
   c_do: cover property (pair_run && peer_di_valid);
endmodule

// ---- src/scp_pkg.sv ----
package scp_pkg;

   // identifier ranges
   localparam logic [7:0] ID_NORM_MIN = 8'h01;
   localparam logic [7:0] ID_NORM_MAX = 8'h7f;
   localparam logic [7:0] ID_PAIR_MIN = 8'h81;
   localparam logic [7:0] ID_PAIR_MAX = 8'hff;
   localparam logic [7:0] ID_STEP = 8'h01;

   // bit-rate switch codes
   localparam logic [3:0] RATE_LAST = 4'h7;
   localparam logic [3:0] RATE_INIT = 4'h9;

   // slot module kinds, as reported by the slot identification pins
   localparam int KIND_W = 3;
   localparam logic [2:0] KIND_NONE = 3'h0;
   localparam logic [2:0] KIND_DI = 3'h1;
   localparam logic [2:0] KIND_DO = 3'h2;
   localparam logic [2:0] KIND_DIO = 3'h3;
   localparam logic [2:0] KIND_AI = 3'h4;
   localparam logic [2:0] KIND_AO = 3'h5;
   localparam logic [2:0] KIND_CNT = 3'h6;

   // edges after reset release before the synchronised pins are trusted
   localparam logic [1:0] SETTLE_CYCLES = 2'h2;

   typedef enum logic [2:0] {
      ST_SETTLE, ST_CHECK, ST_SCAN, ST_RUN, ST_INIT, ST_FAIL
   } scp_state_t;

   // bit rate in kbit/s for a legal switch code
   function automatic logic [9:0] scp_kbps(input logic [3:0] code);
      case (code)
         4'h0: scp_kbps = 10'h00a;
         4'h1: scp_kbps = 10'h014;
         4'h2: scp_kbps = 10'h032;
         4'h3: scp_kbps = 10'h07d;
         4'h4: scp_kbps = 10'h0fa;
         4'h5: scp_kbps = 10'h1f4;
         4'h6: scp_kbps = 10'h320;
         4'h7: scp_kbps = 10'h3e8;
         default: scp_kbps = 10'h000;
      endcase
   endfunction

   // module kinds that produce input process data
   function automatic logic scp_has_in(input logic [2:0] kind);
      scp_has_in = (kind == KIND_DI) || (kind == KIND_DIO) ||
                   (kind == KIND_AI) || (kind == KIND_CNT);
   endfunction

   // module kinds that consume output process data
   function automatic logic scp_has_out(input logic [2:0] kind);
      scp_has_out = (kind == KIND_DO) || (kind == KIND_DIO) ||
                    (kind == KIND_AO);
   endfunction

endpackage

// ---- src/scp_sync.sv ----
`timescale 1ns/1ps
module scp_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // asynchronous in, synchronised out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] stage;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         stage <= '0;
         q <= '0;
      end else begin
         stage <= d;
         q <= stage;
      end
   end

endmodule

// ---- verif/scp_peer.sv ----
`timescale 1ns/1ps
module scp_peer #(
   parameter int DI_W = 16
) (
   // clock
   input wire logic clk,
   // switch pins
   output logic [3:0] id_msb_sw,
   output logic [3:0] id_lsb_sw,
   output logic [3:0] rate_sw,
   // partner node traffic
   output logic [DI_W-1:0] peer_di,
   output logic peer_di_valid,
   input wire logic [DI_W-1:0] di_report,
   input wire logic di_report_valid
);
   logic [DI_W-1:0] last_rep;

   initial begin
      id_msb_sw = 4'h0;
      id_lsb_sw = 4'h0;
      rate_sw = 4'h0;
      peer_di = '0;
      peer_di_valid = 1'b0;
      last_rep = '0;
   end

   ////////////////////////////////////////////////////////////////////////
   // installer: pair ids are only ever set within 81-fe
   task automatic set_sw(input logic [7:0] id, input logic [3:0] rate);
      @(negedge clk);
      {id_msb_sw, id_lsb_sw} = id;
      rate_sw = rate;
   endtask

   // one input report from the partner; data scrambled once released
   task automatic send(input logic [DI_W-1:0] x);
      @(negedge clk);
      peer_di = x;
      peer_di_valid = 1'b1;
      @(negedge clk);
      peer_di_valid = 1'b0;
      peer_di = ~x;
   endtask

   // partner keeps the last reported input state
   always @(posedge clk) begin
      if (di_report_valid === 1'b1) begin
         last_rep <= di_report;
      end
   end
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] id_msb_sw, id_lsb_sw, rate_sw;
   logic [23:0] slot_kind_pins;
   logic [15:0] di_pins, do_pins, peer_di, di_report;
   logic nmt_start_cmd, peer_di_valid, di_report_valid;
   logic [7:0] node_id, peer_id, tx_map, rx_map;
   logic [2:0] rate_sel;
   logic [9:0] rate_kbps;
   logic pair_mode, init_mode, boot_done, boot_fail;
   logic operational, nmt_self_start;
   int failures = 0;
   int tests_run = 0;
   int cycles = 0;
   logic [9:0] kb [0:7] = '{10'h00a, 10'h014, 10'h032, 10'h07d,
                            10'h0fa, 10'h1f4, 10'h320, 10'h3e8};

   always #4 clk = ~clk;

   scp_loader #(.SLOTS(8), .DI_W(16), .INIT_SUPPORT(1'b1)) i_dut (
      .clk(clk), .sys_rst(sys_rst), .id_msb_sw(id_msb_sw),
      .id_lsb_sw(id_lsb_sw), .rate_sw(rate_sw),
      .slot_kind_pins(slot_kind_pins), .di_pins(di_pins),
      .do_pins(do_pins), .nmt_start_cmd(nmt_start_cmd),
      .peer_di(peer_di), .peer_di_valid(peer_di_valid),
      .node_id(node_id), .peer_id(peer_id), .pair_mode(pair_mode),
      .rate_sel(rate_sel), .rate_kbps(rate_kbps), .init_mode(init_mode),
      .boot_done(boot_done), .boot_fail(boot_fail),
      .operational(operational), .nmt_self_start(nmt_self_start),
      .tx_map(tx_map), .rx_map(rx_map), .di_report(di_report),
      .di_report_valid(di_report_valid));

   scp_peer #(.DI_W(16)) i_peer (
      .clk(clk), .id_msb_sw(id_msb_sw), .id_lsb_sw(id_lsb_sw),
      .rate_sw(rate_sw), .peer_di(peer_di),
      .peer_di_valid(peer_di_valid), .di_report(di_report),
      .di_report_valid(di_report_valid));

   ////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      if (failures == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 4000) begin
         failures++;
         finish_test();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // reset with the given switches, then wait for the boot result
   task automatic boot(input logic [7:0] id, input logic [3:0] rate);
      int n;
      i_peer.set_sw(id, rate);
      sys_rst = 1'b1;
      di_pins = 16'h0000;
      repeat (6) @(negedge clk);
      sys_rst = 1'b0;
      n = 0;
      while ((boot_done | boot_fail | init_mode) !== 1'b1 && n < 30) begin
         @(negedge clk);
         n++;
      end
      check(16'(n < 30), 16'h0001);
   endtask

   task automatic nmt_pulse;
      @(negedge clk);
      nmt_start_cmd = 1'b1;
      @(negedge clk);
      nmt_start_cmd = 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_normal;
      logic [7:0] id;
      for (int r = 0; r < 8; r++) begin
         // both ends of the normal id range are visited
         id = (r == 0) ? 8'h01 : (r == 7) ? 8'h7f : 8'h3c;
         boot(id, 4'(r));
         check(16'(node_id), 16'(id));
         check(16'({pair_mode, peer_id}), 16'h0000);
         check(16'(rate_kbps), 16'(kb[r]));
         check(16'(rate_sel), 16'(r));
         // slots 1,3,4,6,7 give inputs; 2,3,5,7 take outputs
         check({tx_map, rx_map}, 16'hdaac);
         check(16'({operational, nmt_self_start}), 16'h0000);
         i_peer.send(16'h00ff);
         @(negedge clk);
         check(do_pins, 16'h0000);
         nmt_pulse();
         check(16'(operational), 16'h0001);
      end
   endtask

   task automatic t_bad;
      logic [11:0] bad [0:4] = '{12'h000, 12'h800, 12'h3c8,
                                 12'h3ca, 12'h3cf};
      for (int i = 0; i < 5; i++) begin
         boot(bad[i][11:4], bad[i][3:0]);
         repeat (3) @(negedge clk);
         check(16'({boot_fail, boot_done, operational}), 16'h0004);
      end
      boot(8'h3c, 4'h9);
      check(16'({init_mode, boot_done, boot_fail}), 16'h0004);
   endtask

   task automatic t_pair;
      logic [7:0] ids [0:2] = '{8'h81, 8'h82, 8'hfe};
      logic [7:0] mates [0:2] = '{8'h82, 8'h81, 8'hfd};
      int n;
      for (int i = 0; i < 3; i++) begin
         boot(ids[i], 4'h1);
         check(16'({pair_mode, peer_id}), {8'h01, mates[i]});
         check(16'({operational, nmt_self_start}), 16'h0003);
         @(negedge clk);
         check(16'(nmt_self_start), 16'h0000);
         i_peer.send(16'ha55a ^ 16'(i));
         @(negedge clk);
         check(do_pins, 16'ha55a ^ 16'(i));
         di_pins = 16'h0081 | 16'(2 * i);
         n = 0;
         while (di_report_valid !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
         end
         check(16'(di_report_valid), 16'h0001);
         check(di_report, 16'h0081 | 16'(2 * i));
         @(negedge clk);
         check(16'(di_report_valid), 16'h0000);
         check(i_peer.last_rep, 16'h0081 | 16'(2 * i));
         i_peer.set_sw(8'h05, 4'h0);
         repeat (4) @(negedge clk);
         check(16'(node_id), 16'(ids[i]));
         check(16'(rate_kbps), 16'h0014);
      end
   endtask

   initial begin
      nmt_start_cmd = 1'b0;
      di_pins = 16'h0000;
      slot_kind_pins = {3'h3, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
      t_normal();
      t_bad();
      t_pair();
      finish_test();
   end
endmodule
